// >>> hdl/lke_pkg.sv
// shared constants and types for the legacy keyboard emulation block
package lke_pkg;
    // memory offsets of the emulation registers
    localparam logic [11:0] CONTROL_OFS = 12'h100;
    localparam logic [11:0] INPUT_OFS   = 12'h104;
    localparam logic [11:0] OUTPUT_OFS  = 12'h108;
    localparam logic [11:0] STATUS_OFS  = 12'h10C;
    // legacy i/o ports and the gate A20 command
    localparam logic [15:0] PORT_DATA   = 16'h0060;
    localparam logic [15:0] PORT_CMD    = 16'h0064;
    localparam logic [7:0]  CMD_A20     = 8'hD1;
    // status field positions
    localparam int ST_OUT_FULL   = 0;
    localparam int ST_IN_FULL    = 1;
    localparam int ST_FLAG       = 2;
    localparam int ST_CMD_DATA   = 3;
    localparam int ST_INHIBIT    = 4;
    localparam int ST_AUX_FULL   = 5;
    localparam int ST_TIMEOUT    = 6;
    localparam int ST_PARITY     = 7;
    // control field positions
    localparam int CT_EMU_ON     = 0;
    localparam int CT_EMU_IRQ    = 1;
    localparam int CT_CHAR_PEND  = 2;
    localparam int CT_IRQ_EN     = 3;
    localparam int CT_EXT_EN     = 4;
    localparam int CT_A20_SEQ    = 5;
    localparam int CT_KBD_SEEN   = 6;
    localparam int CT_MOUSE_SEEN = 7;
    localparam int CT_A20_STATE  = 8;
    // data bit of the port 60h byte that carries the A20 gate value
    localparam int A20_DATA_BIT  = 1;
    // reset values
    localparam logic [7:0]  BYTE_RST    = 8'h00;
    localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

    typedef struct packed {
        logic parity;
        logic timeout;
        logic aux_output_full_c;
        logic inhibit;
        logic command_or_data;
        logic flag;
        logic input_full_b;
        logic output_full_a;
    } lke_status_t;

    typedef struct packed {
        logic a20_gate_state;
        logic mouse_irq_seen;
        logic kbd_irq_seen;
        logic a20_sequence_flag;
        logic external_irq_enable;
        logic legacy_irq_enable;
        logic character_pending_d;
        logic emu_irq_condition;
        logic emulation_on;
    } lke_ctrl_t;

    localparam lke_status_t STATUS_RST = 8'h00;
endpackage : lke_pkg

// >>> hdl/lke_edge.sv
// two-stage synchroniser with rising-edge detect for pin inputs
`timescale 1ns/1ps
module lke_edge #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_pin,
    output logic      [WIDTH-1:0] o_level,
    output logic      [WIDTH-1:0] o_rise
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] prev;

    initial begin
        if (WIDTH < 1) $error("lke_edge: WIDTH must be at least 1");
    end

    // first stage feeds only the second stage
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta  <= '0;
            level <= '0;
            prev  <= '0;
        end else begin
            meta  <= i_pin;
            level <= meta;
            prev  <= level;
        end
    end

    assign o_level = level;
    assign o_rise  = level & ~prev;
endmodule : lke_edge

// >>> hdl/lke_flag.sv
// sticky flags set by hardware, cleared by writing one
`timescale 1ns/1ps
module lke_flag #(
    parameter int WIDTH = 2
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_set,
    input  wire logic [WIDTH-1:0] i_clear,
    output logic      [WIDTH-1:0] o_flag
);
    logic [WIDTH-1:0] flag;
    logic [WIDTH-1:0] next_flag;

    initial begin
        if (WIDTH < 1) $error("lke_flag: WIDTH must be at least 1");
    end

    // set wins over a clear in the same cycle so no edge is lost
    always_comb begin
        next_flag = (flag & ~i_clear) | i_set;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag <= '0;
        end else begin
            flag <= next_flag;
        end
    end

    assign o_flag = flag;
endmodule : lke_flag

// >>> hdl/lke_core.sv
// legacy keyboard controller emulation: i/o port decode, status, irqs
`timescale 1ns/1ps
module lke_core #(
    parameter int MEM_ADDR_W = 12
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst_n,
    // memory cycles from emulation software
    input  wire logic [MEM_ADDR_W-1:0] i_mem_addr,
    input  wire logic                  i_mem_wr,
    input  wire logic                  i_mem_rd,
    input  wire logic [31:0]           i_mem_wdata,
    output logic      [31:0]           o_mem_rdata,
    output logic                       o_mem_ack,
    // legacy i/o cycles
    input  wire logic [15:0]           i_io_addr,
    input  wire logic                  i_io_wr,
    input  wire logic                  i_io_rd,
    input  wire logic [7:0]            i_io_wdata,
    output logic      [7:0]            o_io_rdata,
    output logic                       o_io_claim,
    // keyboard controller and switch pins
    input  wire logic                  i_kbc_irq1,
    input  wire logic                  i_kbc_irq12,
    input  wire logic                  i_kbd_not_inhibited,
    // legacy and emulation interrupts, A20 gate and A20 mismatch
    output logic                       o_irq1,
    output logic                       o_irq12,
    output logic                       o_emu_irq,
    output logic                       o_a20_gate,
    output logic                       o_a20_mismatch
);
    initial begin
        if (MEM_ADDR_W < 12) $error("lke_core: MEM_ADDR_W must be at least 12");
    end

    function automatic logic mem_hit(input logic [MEM_ADDR_W-1:0] addr, input logic [11:0] ofs);
        mem_hit = (addr == MEM_ADDR_W'(ofs));
    endfunction : mem_hit

    localparam int A20_BIT = lke_pkg::A20_DATA_BIT;

    // register state
    logic [7:0]          captured_byte;
    logic [7:0]          return_byte;
    lke_pkg::lke_status_t status;
    logic                emulation_on;
    logic                character_pending_d;
    logic                legacy_irq_enable;
    logic                external_irq_enable;
    logic                a20_sequence_flag;
    logic                a20_gate_state;
    logic [7:0]          next_captured_byte;
    logic [7:0]          next_return_byte;
    lke_pkg::lke_status_t next_status;
    logic                next_emulation_on;
    logic                next_character_pending_d;
    logic                next_legacy_irq_enable;
    logic                next_external_irq_enable;
    logic                next_a20_sequence_flag;
    logic                next_a20_gate_state;
    // output registers
    logic [31:0]         mem_rdata;
    logic                mem_ack;
    logic [7:0]          io_rdata;
    logic                io_claim;
    logic                irq1;
    logic                irq12;
    logic                emu_irq;
    logic                a20_mismatch;
    logic [31:0]         next_mem_rdata;
    logic                next_mem_ack;
    logic [7:0]          next_io_rdata;
    logic                next_io_claim;
    logic                next_irq1;
    logic                next_irq12;
    logic                next_emu_irq;
    logic                next_a20_mismatch;
    // decode
    logic                wr_data_port;
    logic                wr_cmd_port;
    logic                rd_data_port;
    logic                rd_cmd_port;
    logic                a20_data_write;
    logic                emu_irq_condition;
    logic [1:0]          kbc_level;
    logic [1:0]          kbc_rise;
    logic                inhibit_level;
    logic                unused_inhibit_rise;
    logic [1:0]          seen_flags;
    logic [1:0]          seen_clear;
    lke_pkg::lke_status_t status_view;
    lke_pkg::lke_ctrl_t  ctrl_view;

    lke_edge #(
        .WIDTH(3)
    ) u_pins (
        .i_core_clk(i_core_clk),
        .i_rst_n   (i_rst_n),
        .i_pin     ({i_kbd_not_inhibited, i_kbc_irq12, i_kbc_irq1}),
        .o_level   ({inhibit_level, kbc_level}),
        .o_rise    ({unused_inhibit_rise, kbc_rise})
    );

    // clear on a memory write of one to the seen bits
    assign seen_clear = (i_mem_wr && mem_hit(i_mem_addr, lke_pkg::CONTROL_OFS))
                      ? {i_mem_wdata[lke_pkg::CT_MOUSE_SEEN], i_mem_wdata[lke_pkg::CT_KBD_SEEN]}
                      : 2'h0;

    lke_flag #(
        .WIDTH(2)
    ) u_seen (
        .i_core_clk(i_core_clk),
        .i_rst_n   (i_rst_n),
        .i_set     (kbc_rise),
        .i_clear   (seen_clear),
        .o_flag    (seen_flags)
    );

    // i/o decode only while emulating
    assign wr_data_port   = emulation_on && i_io_wr && (i_io_addr == lke_pkg::PORT_DATA);
    assign wr_cmd_port    = emulation_on && i_io_wr && (i_io_addr == lke_pkg::PORT_CMD);
    assign rd_data_port   = emulation_on && i_io_rd && (i_io_addr == lke_pkg::PORT_DATA);
    assign rd_cmd_port    = emulation_on && i_io_rd && (i_io_addr == lke_pkg::PORT_CMD);
    assign a20_data_write = wr_data_port && a20_sequence_flag;

    // status as seen by readers: inhibit follows the switch pin
    always_comb begin
        status_view         = status;
        status_view.inhibit = inhibit_level;
    end

    // live decode, never latched
    always_comb begin
        emu_irq_condition = (emulation_on && status.input_full_b)
                          | (emulation_on && character_pending_d && !status.output_full_a)
                          | (external_irq_enable && (seen_flags[0] || seen_flags[1]));
    end

    always_comb begin
        ctrl_view.emulation_on        = emulation_on;
        ctrl_view.emu_irq_condition   = emu_irq_condition;
        ctrl_view.character_pending_d = character_pending_d;
        ctrl_view.legacy_irq_enable   = legacy_irq_enable;
        ctrl_view.external_irq_enable = external_irq_enable;
        ctrl_view.a20_sequence_flag   = a20_sequence_flag;
        ctrl_view.kbd_irq_seen        = seen_flags[0];
        ctrl_view.mouse_irq_seen      = seen_flags[1];
        ctrl_view.a20_gate_state      = a20_gate_state;
    end

    // register updates: memory writes store, i/o cycles add side effects
    always_comb begin
        next_captured_byte       = captured_byte;
        next_return_byte         = return_byte;
        next_status              = status;
        next_emulation_on        = emulation_on;
        next_character_pending_d = character_pending_d;
        next_legacy_irq_enable   = legacy_irq_enable;
        next_external_irq_enable = external_irq_enable;
        next_a20_sequence_flag   = a20_sequence_flag;
        next_a20_gate_state      = a20_gate_state;
        if (i_mem_wr) begin
            if (mem_hit(i_mem_addr, lke_pkg::INPUT_OFS)) begin
                next_captured_byte = i_mem_wdata[7:0];
            end
            if (mem_hit(i_mem_addr, lke_pkg::OUTPUT_OFS)) begin
                next_return_byte = i_mem_wdata[7:0];
            end
            if (mem_hit(i_mem_addr, lke_pkg::STATUS_OFS)) begin
                next_status         = lke_pkg::lke_status_t'(i_mem_wdata[7:0]);
                next_status.inhibit = 1'b0;
            end
            if (mem_hit(i_mem_addr, lke_pkg::CONTROL_OFS)) begin
                next_emulation_on        = i_mem_wdata[lke_pkg::CT_EMU_ON];
                next_character_pending_d = i_mem_wdata[lke_pkg::CT_CHAR_PEND];
                next_legacy_irq_enable   = i_mem_wdata[lke_pkg::CT_IRQ_EN];
                next_external_irq_enable = i_mem_wdata[lke_pkg::CT_EXT_EN];
                next_a20_sequence_flag   = i_mem_wdata[lke_pkg::CT_A20_SEQ];
                next_a20_gate_state      = i_mem_wdata[lke_pkg::CT_A20_STATE];
            end
        end
        // i/o side effects take priority over a same-cycle memory write
        if (wr_data_port || wr_cmd_port) begin
            next_captured_byte = i_io_wdata;
        end
        if (wr_data_port) begin
            next_status.command_or_data = 1'b0;
            if (a20_sequence_flag) begin
                next_a20_gate_state = i_io_wdata[A20_BIT];
            end else begin
                next_status.input_full_b = 1'b1;
            end
        end
        if (wr_cmd_port) begin
            next_status.command_or_data = 1'b1;
            next_status.input_full_b    = 1'b1;
            next_a20_sequence_flag      = (i_io_wdata == lke_pkg::CMD_A20);
        end
        if (rd_data_port) begin
            next_status.output_full_a = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            captured_byte       <= lke_pkg::BYTE_RST;
            return_byte         <= lke_pkg::BYTE_RST;
            status              <= lke_pkg::STATUS_RST;
            emulation_on        <= 1'b0;
            character_pending_d <= 1'b0;
            legacy_irq_enable   <= 1'b0;
            external_irq_enable <= 1'b0;
            a20_sequence_flag   <= 1'b0;
            a20_gate_state      <= 1'b0;
        end else begin
            captured_byte       <= next_captured_byte;
            return_byte         <= next_return_byte;
            status              <= next_status;
            emulation_on        <= next_emulation_on;
            character_pending_d <= next_character_pending_d;
            legacy_irq_enable   <= next_legacy_irq_enable;
            external_irq_enable <= next_external_irq_enable;
            a20_sequence_flag   <= next_a20_sequence_flag;
            a20_gate_state      <= next_a20_gate_state;
        end
    end

    // read data and interrupt outputs, all registered
    always_comb begin
        next_mem_ack  = i_mem_rd || i_mem_wr;
        next_mem_rdata = 32'h0000_0000;
        if (i_mem_rd) begin
            if (mem_hit(i_mem_addr, lke_pkg::INPUT_OFS)) begin
                next_mem_rdata = {24'h00_0000, captured_byte};
            end else if (mem_hit(i_mem_addr, lke_pkg::OUTPUT_OFS)) begin
                next_mem_rdata = {24'h00_0000, return_byte};
            end else if (mem_hit(i_mem_addr, lke_pkg::STATUS_OFS)) begin
                next_mem_rdata = {24'h00_0000, status_view};
            end else if (mem_hit(i_mem_addr, lke_pkg::CONTROL_OFS)) begin
                next_mem_rdata = {23'h00_0000, ctrl_view};
            end
        end
        next_io_claim = rd_data_port || rd_cmd_port || wr_data_port || wr_cmd_port;
        next_io_rdata = lke_pkg::BYTE_RST;
        if (rd_data_port) begin
            next_io_rdata = return_byte;
        end else if (rd_cmd_port) begin
            next_io_rdata = status_view;
        end
        next_irq1  = emulation_on && legacy_irq_enable && status.output_full_a
                   && !status.aux_output_full_c;
        next_irq12 = emulation_on && legacy_irq_enable && status.output_full_a
                   && status.aux_output_full_c;
        next_emu_irq = emu_irq_condition;
        // mismatch tells the emulation software a real A20 change is wanted
        next_a20_mismatch = a20_mismatch;
        if (a20_data_write) begin
            next_a20_mismatch = (i_io_wdata[A20_BIT] != a20_gate_state);
        end else if (wr_cmd_port) begin
            next_a20_mismatch = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mem_rdata    <= lke_pkg::RDATA_RST;
            mem_ack      <= 1'b0;
            io_rdata     <= lke_pkg::BYTE_RST;
            io_claim     <= 1'b0;
            irq1         <= 1'b0;
            irq12        <= 1'b0;
            emu_irq      <= 1'b0;
            a20_mismatch <= 1'b0;
        end else begin
            mem_rdata    <= next_mem_rdata;
            mem_ack      <= next_mem_ack;
            io_rdata     <= next_io_rdata;
            io_claim     <= next_io_claim;
            irq1         <= next_irq1;
            irq12        <= next_irq12;
            emu_irq      <= next_emu_irq;
            a20_mismatch <= next_a20_mismatch;
        end
    end

    assign o_mem_rdata    = mem_rdata;
    assign o_mem_ack      = mem_ack;
    assign o_io_rdata     = io_rdata;
    assign o_io_claim     = io_claim;
    assign o_irq1         = irq1;
    assign o_irq12        = irq12;
    assign o_emu_irq      = emu_irq;
    assign o_a20_gate     = a20_gate_state;
    assign o_a20_mismatch = a20_mismatch;
endmodule : lke_core

// >>> test/lke_core_asserts.sv
// port checks on the emulation core
`timescale 1ns/1ps
module lke_core_asserts #(
    parameter int MEM_ADDR_W = 12
) (
    input wire logic                  i_core_clk,
    input wire logic                  i_rst_n,
    input wire logic [MEM_ADDR_W-1:0] i_mem_addr,
    input wire logic                  i_mem_wr,
    input wire logic                  i_mem_rd,
    input wire logic [31:0]           i_mem_wdata,
    input wire logic [31:0]           o_mem_rdata,
    input wire logic                  o_mem_ack,
    input wire logic [15:0]           i_io_addr,
    input wire logic                  i_io_wr,
    input wire logic                  i_io_rd,
    input wire logic [7:0]            o_io_rdata,
    input wire logic                  o_io_claim,
    input wire logic                  o_irq1,
    input wire logic                  o_irq12,
    input wire logic                  o_emu_irq,
    input wire logic                  o_a20_gate
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // memory-write shadows
    logic       emu_q;
    logic [7:0] out_q;
    logic       next_emu;
    logic [7:0] next_out;
    logic       io_hit;
    logic       mapped;
    assign io_hit = (i_io_wr || i_io_rd) && (i_io_addr == lke_pkg::PORT_DATA || i_io_addr == lke_pkg::PORT_CMD);
    assign mapped = i_mem_addr inside {lke_pkg::CONTROL_OFS, lke_pkg::INPUT_OFS, lke_pkg::OUTPUT_OFS,
                                       lke_pkg::STATUS_OFS};
    always_comb begin
        next_emu = emu_q;
        next_out = out_q;
        if (i_mem_wr && i_mem_addr == lke_pkg::CONTROL_OFS) next_emu = i_mem_wdata[0];
        if (i_mem_wr && i_mem_addr == lke_pkg::OUTPUT_OFS) next_out = i_mem_wdata[7:0];
    end
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            emu_q <= 1'b0;
            out_q <= 8'h00;
        end else begin
            emu_q <= next_emu;
            out_q <= next_out;
        end
    end
    a_unmapped_zero: assert property ((i_mem_rd && !mapped) |=> o_mem_ack && o_mem_rdata == 32'h0)
        else $error("unmapped read");
    a_byte_reserved: assert property ((i_mem_rd && mapped && i_mem_addr != lke_pkg::CONTROL_OFS)
        |=> o_mem_rdata[31:8] == 24'h0)
        else $error("reserved bits");
    a_ctrl_readback: assert property ((i_mem_rd && i_mem_addr == lke_pkg::CONTROL_OFS)
        |=> o_mem_rdata[31:9] == 23'h0 && o_mem_rdata[0] == $past(emu_q))
        else $error("control readback");
    a_claim_on: assert property ((emu_q && io_hit) |=> o_io_claim)
        else $error("no claim");
    a_claim_off: assert property ((!emu_q && (i_io_wr || i_io_rd)) |=> !o_io_claim)
        else $error("claim when off");
    a_port_read_byte: assert property ((emu_q && i_io_rd && i_io_addr == lke_pkg::PORT_DATA)
        |=> o_io_rdata == $past(out_q))
        else $error("port read byte");
    a_irq_exclusive: assert property (!(o_irq1 && o_irq12))
        else $error("both irqs high");
    a_irq_gated: assert property ((!emu_q && !$past(emu_q)) |-> !o_irq1 && !o_irq12)
        else $error("irq while disabled");
    a_write_raises_emu: assert property ((emu_q && i_io_wr && i_io_addr == lke_pkg::PORT_CMD) |=> ##1 o_emu_irq)
        else $error("no emulation irq");
    a_gate_cause: assert property ($changed(o_a20_gate) |-> $past(i_io_wr || i_mem_wr))
        else $error("gate change without write");
    c_irq1: cover property (o_irq1);
    c_irq12: cover property (o_irq12);
    c_gate: cover property (o_a20_gate);
    c_ext_irq: cover property (o_emu_irq && !emu_q);
endmodule : lke_core_asserts

bind lke_core lke_core_asserts #(.MEM_ADDR_W(MEM_ADDR_W)) u_asserts (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_mem_addr(i_mem_addr), .i_mem_wr(i_mem_wr),
    .i_mem_rd(i_mem_rd), .i_mem_wdata(i_mem_wdata), .o_mem_rdata(o_mem_rdata), .o_mem_ack(o_mem_ack),
    .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .o_io_rdata(o_io_rdata),
    .o_io_claim(o_io_claim), .o_irq1(o_irq1), .o_irq12(o_irq12), .o_emu_irq(o_emu_irq), .o_a20_gate(o_a20_gate)
);

// >>> test/lke_kbc_model.sv
// keyboard controller model
`timescale 1ns/1ps
module lke_kbc_model (
    input  wire logic i_core_clk,
    input  wire logic i_kbd_req,
    input  wire logic i_mouse_req,
    input  wire logic i_unlock,
    output logic      o_irq1,
    output logic      o_irq12,
    output logic      o_not_inhibited
);
    // pins move on the falling edge; a one-cycle slip is harmless
    always @(negedge i_core_clk) begin
        o_irq1 <= i_kbd_req;
        o_irq12 <= i_mouse_req;
        o_not_inhibited <= i_unlock;
    end
endmodule : lke_kbc_model

// >>> test/tb_legacy_keyboard_emulation.sv
// self-checking bench for the emulation core
`timescale 1ns/1ps
module tb_legacy_keyboard_emulation;
    localparam A_CT = lke_pkg::CONTROL_OFS;
    localparam A_IN = lke_pkg::INPUT_OFS;
    localparam A_OUT = lke_pkg::OUTPUT_OFS;
    localparam A_ST = lke_pkg::STATUS_OFS;
    localparam P_DAT = lke_pkg::PORT_DATA;
    localparam P_CMD = lke_pkg::PORT_CMD;
    logic        i_core_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [11:0] i_mem_addr;
    logic        i_mem_wr = 1'b0;
    logic        i_mem_rd = 1'b0;
    logic [31:0] i_mem_wdata;
    logic [15:0] i_io_addr;
    logic        i_io_wr = 1'b0;
    logic        i_io_rd = 1'b0;
    logic [7:0]  i_io_wdata;
    logic        kbd_req = 1'b0;
    logic        mouse_req = 1'b0;
    logic        unlock = 1'b0;
    logic [31:0] o_mem_rdata;
    logic [7:0]  o_io_rdata;
    logic        o_mem_ack, o_io_claim, kbc_irq1, kbc_irq12, not_inh;
    logic        o_irq1, o_irq12, o_emu_irq, o_a20_gate, o_a20_mismatch;
    int          num_errors = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          seed = 32'h5AA1;
    logic [7:0]  b;
    logic [31:0] q;

    lke_core u_dut (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_mem_addr(i_mem_addr), .i_mem_wr(i_mem_wr),
        .i_mem_rd(i_mem_rd), .i_mem_wdata(i_mem_wdata), .o_mem_rdata(o_mem_rdata), .o_mem_ack(o_mem_ack),
        .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
        .o_io_rdata(o_io_rdata), .o_io_claim(o_io_claim), .i_kbc_irq1(kbc_irq1), .i_kbc_irq12(kbc_irq12),
        .i_kbd_not_inhibited(not_inh), .o_irq1(o_irq1), .o_irq12(o_irq12), .o_emu_irq(o_emu_irq),
        .o_a20_gate(o_a20_gate), .o_a20_mismatch(o_a20_mismatch)
    );
    lke_kbc_model u_kbc (
        .i_core_clk(i_core_clk), .i_kbd_req(kbd_req), .i_mouse_req(mouse_req), .i_unlock(unlock),
        .o_irq1(kbc_irq1), .o_irq12(kbc_irq12), .o_not_inhibited(not_inh)
    );

    initial begin
        forever #12.5 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            end_of_test();
        end
    end

    function automatic logic [31:0] st(input logic of, input logic inf, input logic cd, input logic ax);
        return {26'h000_0000, ax, 1'b0, cd, 1'b0, inf, of};
    endfunction : st
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word
    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit
    task automatic mem(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(negedge i_core_clk);
        i_mem_wr = wr;
        i_mem_rd = !wr;
        i_mem_addr = a;
        i_mem_wdata = d;
        @(negedge i_core_clk);
        i_mem_wr = 1'b0;
        i_mem_rd = 1'b0;
        q = o_mem_rdata;
        chk_bit("mem_ack", 1'b1, o_mem_ack);
    endtask : mem
    task automatic io(input logic wr, input logic [15:0] p, input logic [7:0] d, input logic c);
        @(negedge i_core_clk);
        i_io_wr = wr;
        i_io_rd = !wr;
        i_io_addr = p;
        i_io_wdata = d;
        @(negedge i_core_clk);
        i_io_wr = 1'b0;
        i_io_rd = 1'b0;
        q = 32'(o_io_rdata);
        chk_bit("io_claim", c, o_io_claim);
    endtask : io
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        mem(1'b0, a, 32'h0);
        chk_word(what, exp, q);
    endtask : rd_chk
    task automatic pulse(ref logic r);
        @(negedge i_core_clk);
        r = 1'b1;
        repeat (2) @(negedge i_core_clk);
        r = 1'b0;
        repeat (5) @(negedge i_core_clk);
    endtask : pulse
    task automatic end_of_test();
        $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        rd_chk(A_CT, 32'h0, "ctrl_rst");
        rd_chk(12'h110, 32'h0, "unmapped");
        io(1'b1, P_DAT, 8'h55, 1'b0);
        rd_chk(A_ST, 32'h0, "status_off");
        $display("test reset done");
        mem(1'b1, A_CT, 32'h1);
        for (int i = 0; i < 6; i++) begin
            b = 8'($random(seed));
            if (b == lke_pkg::CMD_A20) b = 8'hD0;
            io(1'b1, i[0] ? P_CMD : P_DAT, b, 1'b1);
            rd_chk(A_IN, 32'(b), "input");
            rd_chk(A_ST, st(1'b0, 1'b1, i[0], 1'b0), "status_wr");
            rd_chk(A_CT, 32'h3, "ctrl_decode");
            chk_bit("emu_irq", 1'b1, o_emu_irq);
        end
        mem(1'b1, A_IN, $random(seed));
        rd_chk(A_ST, st(1'b0, 1'b1, 1'b1, 1'b0), "status_mem");
        mem(1'b1, A_ST, 32'hFFFF_FF00);
        rd_chk(A_ST, 32'h0, "status_resv");
        chk_bit("emu_irq_off", 1'b0, o_emu_irq);
        $display("test capture done");
        mem(1'b1, A_CT, 32'h9);
        for (int ax = 0; ax < 2; ax++) begin
            b = 8'($random(seed));
            mem(1'b1, A_OUT, 32'(b));
            mem(1'b1, A_ST, st(1'b1, 1'b0, 1'b0, ax[0]));
            @(negedge i_core_clk);
            chk_bit("irq1", !ax[0], o_irq1);
            chk_bit("irq12", ax[0], o_irq12);
            io(1'b0, P_DAT, 8'h00, 1'b1);
            chk_word("port_data", 32'(b), q);
            @(negedge i_core_clk);
            chk_bit("irq_clr", 1'b0, o_irq1 | o_irq12);
            rd_chk(A_ST, st(1'b0, 1'b0, 1'b0, ax[0]), "status_rd");
        end
        mem(1'b1, A_ST, 32'hE5);
        io(1'b0, P_CMD, 8'h00, 1'b1);
        chk_word("port_status", 32'hE5, q);
        rd_chk(A_ST, 32'hE5, "status_keep");
        $display("test irq done");
        mem(1'b1, A_ST, 32'h0);
        mem(1'b1, A_CT, 32'h5);
        @(negedge i_core_clk);
        chk_bit("emu_pend", 1'b1, o_emu_irq);
        mem(1'b1, A_ST, 32'h1);
        rd_chk(A_CT, 32'h5, "ctrl_pend");
        mem(1'b1, A_ST, 32'h0);
        mem(1'b1, A_CT, 32'h1);
        io(1'b1, P_CMD, lke_pkg::CMD_A20, 1'b1);
        rd_chk(A_CT, 32'h23, "ctrl_seq");
        mem(1'b1, A_ST, 32'h0);
        io(1'b1, P_DAT, 8'h02, 1'b1);
        rd_chk(A_ST, 32'h0, "status_a20");
        rd_chk(A_CT, 32'h121, "ctrl_a20");
        chk_bit("a20_gate", 1'b1, o_a20_gate);
        chk_bit("a20_mismatch", 1'b1, o_a20_mismatch);
        io(1'b1, P_CMD, 8'h20, 1'b1);
        rd_chk(A_CT, 32'h103, "ctrl_seq_end");
        $display("test a20 done");
        mem(1'b1, A_CT, 32'h10);
        pulse(kbd_req);
        rd_chk(A_CT, 32'h52, "ctrl_kbd");
        chk_bit("emu_ext", 1'b1, o_emu_irq);
        mem(1'b1, A_CT, 32'h10);
        rd_chk(A_CT, 32'h52, "ctrl_w0");
        mem(1'b1, A_CT, 32'h50);
        rd_chk(A_CT, 32'h10, "ctrl_w1c");
        pulse(mouse_req);
        rd_chk(A_CT, 32'h92, "ctrl_mouse");
        unlock = 1'b1;
        repeat (5) @(negedge i_core_clk);
        rd_chk(A_ST, 32'h1A, "status_inh");
        $display("test external done");
        end_of_test();
    end
endmodule : tb_legacy_keyboard_emulation
